// ==== hw/shs_homing.sv ====
// Notes on behaviour
// - methods 0-9 use switch, limit or index
// - method 10 runs straight to absolute target
// - method 0 forward, home switch both points
// - method 0 home rise forward is home
// - method 0 limit: reverse fast, stop switch
// - method 0 switch high: reverse slow, fall
// - method 2 decel on switch, then index
// - method 2 first forward index is home
// - method 2 limit: reverse to fall, index
// - method 2 switch high: reverse slow, index
// - method 4 forward limit both points
// - method 4 limit rising edge is home
// - method 4 limit active: reverse to fall
// - method 6 limit decel, index home
// - method 6 first reverse index after limit
// - method 6 limit active: reverse, fall, index
// - decel point switches high to low speed
// - method field selects zero to ten
// - done on success, off on fail/abort
//
// Design decisions made here: the address map and the AXI4-Lite register port.
module shs_homing (
  // clock, enable, reset
  input  wire logic         CLK,
  input  wire logic         CE,
  input  wire logic         RST_N,
  // axi4-lite write address
  input  wire logic [7:0]   S_AXI_AWADDR,
  input  wire logic         S_AXI_AWVALID,
  output logic              S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0]  S_AXI_WDATA,
  input  wire logic [3:0]   S_AXI_WSTRB,
  input  wire logic         S_AXI_WVALID,
  output logic              S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]        S_AXI_BRESP,
  output logic              S_AXI_BVALID,
  input  wire logic         S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [7:0]   S_AXI_ARADDR,
  input  wire logic         S_AXI_ARVALID,
  output logic              S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0]       S_AXI_RDATA,
  output logic [1:0]        S_AXI_RRESP,
  output logic              S_AXI_RVALID,
  input  wire logic         S_AXI_RREADY,
  // switch and encoder pins
  input  wire logic         HOME_SWITCH_INPUT,
  input  wire logic         FORWARD_TRAVEL_LIMIT,
  input  wire logic         REVERSE_TRAVEL_LIMIT,
  input  wire logic         INDEX_PULSE,
  // encoder position, same clock domain
  input  wire logic [15:0]  POS_MULTITURN,
  input  wire logic [31:0]  POS_SINGLETURN,
  // motor command
  output logic              MOTOR_RUN,
  output logic              MOTOR_DIR_REV,
  output logic [15:0]       MOTOR_SPEED,
  // completion
  output logic              HOMING_DONE_OUTPUT
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    shs_pkg::shs_phase_e phase;        // sequencer phase
    logic [3:0]          method;       // homing_method_select
    logic [15:0]         hi_speed;     // high homing speed
    logic [15:0]         lo_speed;     // low homing speed
    logic [15:0]         abs_mt;       // abs_zero_multiturn_cfg
    logic [31:0]         abs_st;       // abs_zero_singleturn_cfg
    logic                done;         // homing_done_output
    logic                fail;         // last run interrupted
    logic                slow;         // decel point passed
    logic                go;           // start, one cycle late so a new method applies
    shs_pkg::shs_motor_s mot;          // motor command
    logic                aw_hold;      // write address taken
    logic [7:0]          aw_addr;
    logic                w_hold;       // write data taken
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } shs_state_s;

  shs_state_s        r;
  shs_state_s        next_r;
  shs_pkg::shs_evt_s evt;      // synchronised pin events
  logic              mirror;   // odd method
  logic              use_idx;  // index is final point
  logic              dec_lim;  // limit is decel point

  // ************************************************************
  // pin conditioning
  // ************************************************************
  shs_input_sync u_sync (
    .clk       (CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .home_pin  (HOME_SWITCH_INPUT),
    .fwd_pin   (FORWARD_TRAVEL_LIMIT),
    .rev_pin   (REVERSE_TRAVEL_LIMIT),
    .index_pin (INDEX_PULSE),
    .evt       (evt)
  );

  // merge a 32-bit write under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return m;
  endfunction : merge

  // method class decode
  assign mirror  = r.method[0];
  assign use_idx = (r.method == 4'h2) | (r.method == 4'h3) |
                   (r.method == 4'h6) | (r.method == 4'h7);
  assign dec_lim = (r.method[3:1] == 3'h2) | (r.method[3:1] == 3'h3);

  // ************************************************************
  // next state
  // ************************************************************
  // mirrored views: "fwd" is the start direction's limit
  logic lim_lvl, lim_rise, lim_fall, start, abort, wr_go;
  logic [31:0] ctrl_wd;

  always_comb begin
    next_r   = r;
    lim_lvl  = mirror ? evt.rev_lvl  : evt.fwd_lvl;
    lim_rise = mirror ? evt.rev_rise : evt.fwd_rise;
    lim_fall = mirror ? evt.rev_fall : evt.fwd_fall;
    wr_go    = r.aw_hold & r.w_hold & ~r.bvalid;
    ctrl_wd  = merge(32'h0000_0000, r.w_data, r.w_strb);
    start    = wr_go & (r.aw_addr == shs_pkg::OFS_CTRL) & ctrl_wd[shs_pkg::CTRL_START_BIT];
    abort    = wr_go & (r.aw_addr == shs_pkg::OFS_CTRL) & ctrl_wd[shs_pkg::CTRL_ABORT_BIT];
    // delay start a cycle: a method written with it must be decoded first
    next_r.go = start;

    // --- write channel: take address and data in any order
    if (S_AXI_AWVALID & ~r.aw_hold) begin
      next_r.aw_hold = 1'b1;
      next_r.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & ~r.w_hold) begin
      next_r.w_hold = 1'b1;
      next_r.w_data = S_AXI_WDATA;
      next_r.w_strb = S_AXI_WSTRB;
    end
    if (wr_go) begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = shs_pkg::RESP_OKAY;
      unique case (r.aw_addr)
        shs_pkg::OFS_CTRL: begin
          // method only changes while idle; out of range refused while idle
          if (r.phase == shs_pkg::SHS_IDLE) begin
            if (ctrl_wd[shs_pkg::CTRL_METH_LSB +: 4] <= shs_pkg::METH_ABS) begin
              next_r.method = ctrl_wd[shs_pkg::CTRL_METH_LSB +: 4];
            end else begin
              next_r.bresp = shs_pkg::RESP_SLVERR;
            end
          end
        end
        shs_pkg::OFS_HI_SPEED: next_r.hi_speed = 16'(merge({16'h0000, r.hi_speed},
                                                           r.w_data, r.w_strb));
        shs_pkg::OFS_LO_SPEED: next_r.lo_speed = 16'(merge({16'h0000, r.lo_speed},
                                                           r.w_data, r.w_strb));
        shs_pkg::OFS_ABS_MT:   next_r.abs_mt = 16'(merge({16'h0000, r.abs_mt},
                                                         r.w_data, r.w_strb));
        shs_pkg::OFS_ABS_ST:   next_r.abs_st = merge(r.abs_st, r.w_data, r.w_strb);
        shs_pkg::OFS_STATUS, shs_pkg::OFS_POS_MT, shs_pkg::OFS_POS_ST: begin
          // read-only words ignore writes
        end
        default: next_r.bresp = shs_pkg::RESP_SLVERR;
      endcase
    end
    if (r.bvalid & S_AXI_BREADY) next_r.bvalid = 1'b0;

    // --- read channel: one cycle to answer
    next_r.arready = 1'b0;
    if (S_AXI_ARVALID & ~r.arready & ~r.rvalid) begin
      next_r.arready = 1'b1;
      next_r.rvalid  = 1'b1;
      next_r.rresp   = shs_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR)
        shs_pkg::OFS_CTRL:     next_r.rdata = {24'h000000, r.method, 4'h0};
        shs_pkg::OFS_HI_SPEED: next_r.rdata = {16'h0000, r.hi_speed};
        shs_pkg::OFS_LO_SPEED: next_r.rdata = {16'h0000, r.lo_speed};
        shs_pkg::OFS_ABS_MT:   next_r.rdata = {16'h0000, r.abs_mt};
        shs_pkg::OFS_ABS_ST:   next_r.rdata = r.abs_st;
        shs_pkg::OFS_STATUS:   next_r.rdata = {24'h000000, 3'h0, r.mot.dir_rev, r.slow,
                                               r.fail, (r.phase != shs_pkg::SHS_IDLE),
                                               r.done};
        shs_pkg::OFS_POS_MT:   next_r.rdata = {16'h0000, POS_MULTITURN};
        shs_pkg::OFS_POS_ST:   next_r.rdata = POS_SINGLETURN;
        default: begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = shs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (r.rvalid & S_AXI_RREADY) next_r.rvalid = 1'b0;

    // --- homing sequencer
    unique case (r.phase)
      shs_pkg::SHS_IDLE: begin
        if (r.go) begin
          next_r.done     = 1'b0;
          next_r.fail     = 1'b0;
          next_r.slow     = 1'b0;
          next_r.mot.run  = 1'b1;
          next_r.mot.speed = r.hi_speed;
          next_r.mot.dir_rev = mirror;
          if (r.method == shs_pkg::METH_ABS) begin
            next_r.phase = shs_pkg::SHS_ABS;
            next_r.mot.dir_rev = ({POS_MULTITURN, POS_SINGLETURN} >
                                  {r.abs_mt, r.abs_st});
          end else if (r.method[3:1] == 3'h4) begin
            next_r.phase = shs_pkg::SHS_FAST;     // index search only
          end else if (!dec_lim && evt.home_lvl) begin
            next_r.phase = shs_pkg::SHS_SLOW;
            next_r.slow = 1'b1;
            next_r.mot.speed = r.lo_speed;
            next_r.mot.dir_rev = ~mirror;
          end else if (dec_lim && lim_lvl) begin
            // index routes run fast until the limit's falling edge
            next_r.phase = shs_pkg::SHS_SLOW;
            next_r.slow = ~use_idx;
            next_r.mot.speed = use_idx ? r.hi_speed : r.lo_speed;
            next_r.mot.dir_rev = ~mirror;
          end else begin
            next_r.phase = shs_pkg::SHS_FAST;
          end
        end
      end
      shs_pkg::SHS_FAST: begin
        if (r.method[3:1] == 3'h4) begin
          if (evt.index) begin                    // index is both points
            next_r.phase = shs_pkg::SHS_STOP;
            next_r.mot.run = 1'b0;
          end
        end else if (dec_lim) begin
          if (lim_rise) begin
            next_r.slow = 1'b1;
            next_r.mot.speed = r.lo_speed;
            if (use_idx) begin
              next_r.phase = shs_pkg::SHS_INDEX;
              next_r.mot.dir_rev = ~mirror;
            end else begin
              next_r.phase = shs_pkg::SHS_STOP;
              next_r.mot.run = 1'b0;
            end
          end
        end else if (evt.home_rise) begin
          next_r.slow = 1'b1;
          next_r.mot.speed = r.lo_speed;
          if (use_idx) begin
            next_r.phase = shs_pkg::SHS_INDEX;
          end else begin
            next_r.phase = shs_pkg::SHS_STOP;
            next_r.mot.run = 1'b0;
          end
        end else if (lim_rise | lim_lvl) begin
          next_r.phase = shs_pkg::SHS_BACK;
          next_r.mot.dir_rev = ~mirror;
        end
      end
      shs_pkg::SHS_BACK: begin
        // reversing at high speed off the limit
        if (!use_idx && evt.home_rise) begin
          next_r.phase = shs_pkg::SHS_STOP;
          next_r.mot.run = 1'b0;
        end else if (use_idx && evt.home_fall) begin
          next_r.phase = shs_pkg::SHS_INDEX;
          next_r.slow = 1'b1;
          next_r.mot.speed = r.lo_speed;
          next_r.mot.dir_rev = mirror;
        end
      end
      shs_pkg::SHS_SLOW: begin
        // started on the decel point, seek its falling edge in reverse
        if ((dec_lim && lim_fall) || (!dec_lim && evt.home_fall)) begin
          if (use_idx) begin
            next_r.phase = shs_pkg::SHS_INDEX;
            next_r.mot.dir_rev = dec_lim ? ~mirror : mirror;
            next_r.slow = 1'b1;
            next_r.mot.speed = r.lo_speed;
          end else begin
            next_r.phase = shs_pkg::SHS_STOP;
            next_r.mot.run = 1'b0;
          end
        end
      end
      shs_pkg::SHS_INDEX: begin
        if (evt.index) begin
          next_r.phase = shs_pkg::SHS_STOP;
          next_r.mot.run = 1'b0;
        end
      end
      shs_pkg::SHS_ABS: begin
        if ({POS_MULTITURN, POS_SINGLETURN} == {r.abs_mt, r.abs_st}) begin
          next_r.phase = shs_pkg::SHS_STOP;
          next_r.mot.run = 1'b0;
        end
      end
      shs_pkg::SHS_STOP: begin
        // motor already stopped a cycle ago, now report
        next_r.phase = shs_pkg::SHS_IDLE;
        next_r.done = 1'b1;
        next_r.mot.speed = 16'h0000;
      end
    endcase
    // an abort beats every phase but idle and drops completion
    if (abort && r.phase != shs_pkg::SHS_IDLE) begin
      next_r.phase = shs_pkg::SHS_IDLE;
      next_r.mot.run = 1'b0;
      next_r.mot.speed = 16'h0000;
      next_r.done = 1'b0;
      next_r.fail = 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r          <= '0;
      r.phase    <= shs_pkg::SHS_IDLE;
      r.hi_speed <= shs_pkg::HI_SPEED_RST;
      r.lo_speed <= shs_pkg::LO_SPEED_RST;
    end else if (CE) begin
      r <= next_r;
    end
  end

  // outputs straight from state flops
  assign S_AXI_AWREADY      = ~r.aw_hold;
  assign S_AXI_WREADY       = ~r.w_hold;
  assign S_AXI_BVALID       = r.bvalid;
  assign S_AXI_BRESP        = r.bresp;
  assign S_AXI_ARREADY      = r.arready;
  assign S_AXI_RVALID       = r.rvalid;
  assign S_AXI_RDATA        = r.rdata;
  assign S_AXI_RRESP        = r.rresp;
  assign MOTOR_RUN          = r.mot.run;
  assign MOTOR_DIR_REV      = r.mot.dir_rev;
  assign MOTOR_SPEED        = r.mot.speed;
  assign HOMING_DONE_OUTPUT = r.done;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_stopped;
    !MOTOR_RUN;
  endsequence

  a_done_after_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(HOMING_DONE_OUTPUT) |-> $past(!MOTOR_RUN))
    else $error("done rose while motor ran");

  a_done_motor_off: assert property (@(posedge CLK) disable iff (!RST_N)
    HOMING_DONE_OUTPUT |-> s_stopped)
    else $error("motor runs while done");

  a_slow_speed: assert property (@(posedge CLK) disable iff (!RST_N)
    (r.slow && MOTOR_RUN) |-> (MOTOR_SPEED == r.lo_speed))
    else $error("low speed not used after decel");

  a_fast_speed: assert property (@(posedge CLK) disable iff (!RST_N)
    (r.phase == shs_pkg::SHS_FAST) |-> (MOTOR_SPEED == r.hi_speed))
    else $error("search not at high speed");

  a_method_range: assert property (@(posedge CLK) disable iff (!RST_N)
    r.method <= shs_pkg::METH_ABS)
    else $error("method out of range");

  a_fast_dir: assert property (@(posedge CLK) disable iff (!RST_N)
    (r.phase == shs_pkg::SHS_FAST) |-> (MOTOR_DIR_REV == mirror))
    else $error("wrong start direction");

  a_abort_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && abort && r.phase != shs_pkg::SHS_IDLE) |=> !HOMING_DONE_OUTPUT && !MOTOR_RUN)
    else $error("abort did not stop");

  a_back_reverse: assert property (@(posedge CLK) disable iff (!RST_N)
    (r.phase == shs_pkg::SHS_BACK) |-> (MOTOR_DIR_REV != mirror) &&
                                       (MOTOR_SPEED == r.hi_speed))
    else $error("limit reversal wrong");

  a_stop_then_done: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && r.phase == shs_pkg::SHS_STOP && !abort) |=> HOMING_DONE_OUTPUT)
    else $error("done not raised after stop");

endmodule : shs_homing

// ==== hw/shs_pkg.sv ====
package shs_pkg;

  // ************************************************************
  // register map (aligned 32-bit words)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;  // start, abort, method
  localparam logic [7:0] OFS_HI_SPEED = 8'h04;  // high homing speed
  localparam logic [7:0] OFS_LO_SPEED = 8'h08;  // low homing speed
  localparam logic [7:0] OFS_ABS_MT   = 8'h0C;  // absolute target multi-turn
  localparam logic [7:0] OFS_ABS_ST   = 8'h10;  // absolute target single-turn
  localparam logic [7:0] OFS_STATUS   = 8'h14;  // sequencer state, read only
  localparam logic [7:0] OFS_POS_MT   = 8'h18;  // current multi-turn, read only
  localparam logic [7:0] OFS_POS_ST   = 8'h1C;  // current single-turn, read only

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_START_BIT = 0;   // write 1 starts homing
  localparam int CTRL_ABORT_BIT = 1;   // write 1 interrupts homing
  localparam int CTRL_METH_LSB  = 4;   // method field, 4 bits
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_BUSY_BIT  = 1;
  localparam int STAT_FAIL_BIT  = 2;
  localparam int STAT_SLOW_BIT  = 3;
  localparam int STAT_DIR_BIT   = 4;

  // ************************************************************
  // reset values and codes
  // ************************************************************
  localparam logic [15:0] HI_SPEED_RST = 16'h03E8;  // 1000 x 0.1 rpm
  localparam logic [15:0] LO_SPEED_RST = 16'h0064;  // 100 x 0.1 rpm
  localparam logic [3:0]  METH_ABS     = 4'hA;      // highest legal method
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // sequencer phases
  typedef enum logic [2:0] {
    SHS_IDLE,   // waiting for start
    SHS_FAST,   // high speed search
    SHS_BACK,   // reversed off a limit at high speed
    SHS_SLOW,   // reverse search off the decel point for its falling edge
    SHS_INDEX,  // waiting for index pulse
    SHS_ABS,    // run to absolute target
    SHS_STOP    // motor held stopped, report
  } shs_phase_e;

  // edge events from the input conditioner
  typedef struct packed {
    logic home_rise;
    logic home_fall;
    logic fwd_rise;
    logic fwd_fall;
    logic rev_rise;
    logic rev_fall;
    logic index;
    logic home_lvl;
    logic fwd_lvl;
    logic rev_lvl;
  } shs_evt_s;

  // motor command bundle
  typedef struct packed {
    logic        run;
    logic        dir_rev;
    logic [15:0] speed;
  } shs_motor_s;

endpackage : shs_pkg

// ==== hw/shs_input_sync.sv ====
// two-stage synchronisers plus edge detection for the switch pins
module shs_input_sync (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // raw pins
  input  wire logic             home_pin,
  input  wire logic             fwd_pin,
  input  wire logic             rev_pin,
  input  wire logic             index_pin,
  // conditioned events
  output shs_pkg::shs_evt_s     evt
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [3:0] s1;   // first stage, read only by s2
    logic [3:0] s2;   // second stage
    logic [3:0] s3;   // previous s2 for edges
  } shs_sync_s;

  shs_sync_s r;
  shs_sync_s next_r;

  // shift the pins through all three stages
  always_comb begin
    next_r    = r;
    next_r.s1 = {index_pin, rev_pin, fwd_pin, home_pin};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  // register stage, frozen by clock enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // edges are qualified by ce so one edge gives one pulse
  always_comb begin
    evt.home_rise = ce & r.s2[0] & ~r.s3[0];
    evt.home_fall = ce & ~r.s2[0] & r.s3[0];
    evt.fwd_rise  = ce & r.s2[1] & ~r.s3[1];
    evt.fwd_fall  = ce & ~r.s2[1] & r.s3[1];
    evt.rev_rise  = ce & r.s2[2] & ~r.s3[2];
    evt.rev_fall  = ce & ~r.s2[2] & r.s3[2];
    evt.index     = ce & r.s2[3] & ~r.s3[3];
    evt.home_lvl  = r.s2[0];
    evt.fwd_lvl   = r.s2[1];
    evt.rev_lvl   = r.s2[2];
  end

endmodule : shs_input_sync

// ==== verif/shs_motor_model.sv ====
// axis, switches and encoder index seen from the drive side
module shs_motor_model (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic dir_rev,
  output logic      home_sw,
  output logic      fwd_lim,
  output logic      rev_lim,
  output logic      index_p,
  output logic [31:0] pos_st
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos = 0;  // axis position, bench may place it while idle
  // one count per cycle; speed is not modelled, so overshoot is only latency
  always @(posedge clk) if (run) pos <= dir_rev ? pos - 1 : pos + 1;
  assign home_sw = (pos >= 32'h190) && (pos <= 32'h1B8);  // cam spans 400..440
  assign fwd_lim = pos >= 32'h2BC;                         // forward stop at 700
  assign rev_lim = pos <= 32'h064;                         // reverse stop at 100
  assign index_p = (pos % 50) == 25;                       // one index a turn
  assign pos_st  = 32'(pos);
endmodule : shs_motor_model

// ==== verif/servo_homing_sequencer_test.sv ====
module servo_homing_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  // method, start, lowest and highest home position, speed soon after start (0: not checked)
  typedef struct packed {logic [3:0] m; logic [31:0] st, lo, hi; logic [15:0] spd;} shs_row_s;
  logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
  logic        rry = 1'b0, awrdy, wrdy, bv, arrdy, rv, run, dir, done, home, fwd, rev, idx;
  logic [7:0]  aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rdat, pst, d;
  logic [1:0]  br, rr, rsp;
  logic [15:0] spd;
  int          n_mismatch = 0, n_compared = 0;
  shs_row_s    rows [14] = '{
    '{4'h0, 32'h0C8, 32'h190, 32'h196, 16'h0200},
    '{4'h0, 32'h1F4, 32'h1B2, 32'h1B8, 16'h0200},
    '{4'h0, 32'h1A4, 32'h189, 32'h18F, 16'h0020},
    '{4'h1, 32'h258, 32'h1B2, 32'h1B8, 16'h0200},
    '{4'h2, 32'h0C8, 32'h1A9, 32'h1AF, 16'h0200},
    '{4'h2, 32'h1F4, 32'h1A9, 32'h1AF, 16'h0200},
    '{4'h2, 32'h1A4, 32'h1A9, 32'h1AF, 16'h0020},
    '{4'h4, 32'h1F4, 32'h2BC, 32'h2C2, 16'h0200},
    '{4'h4, 32'h2EE, 32'h2B5, 32'h2BB, 16'h0000},
    '{4'h5, 32'h12C, 32'h05E, 32'h064, 16'h0200},
    '{4'h6, 32'h1F4, 32'h29D, 32'h2A3, 16'h0200},
    '{4'h6, 32'h2EE, 32'h29D, 32'h2A3, 16'h0200},
    '{4'h8, 32'h0C8, 32'h0E1, 32'h0E7, 16'h0200},
    '{4'hA, 32'h1F4, 32'h126, 32'h12C, 16'h0200}};
  always #20 clk = ~clk;
  shs_homing i_dut (
    .CLK(clk), .CE(1'b1), .RST_N(rst_n),
    .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .HOME_SWITCH_INPUT(home), .FORWARD_TRAVEL_LIMIT(fwd), .REVERSE_TRAVEL_LIMIT(rev),
    .INDEX_PULSE(idx), .POS_MULTITURN(16'h0000), .POS_SINGLETURN(pst),
    .MOTOR_RUN(run), .MOTOR_DIR_REV(dir), .MOTOR_SPEED(spd), .HOMING_DONE_OUTPUT(done));
  shs_motor_model i_mot (.clk(clk), .run(run), .dir_rev(dir), .home_sw(home), .fwd_lim(fwd),
    .rev_lim(rev), .index_p(idx), .pos_st(pst));
  // ****************
  // bus and checks
  // ****************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    aw <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    rsp = br;
    bry <= 1'b0;
    @(posedge clk);  // lets bvalid drop before the next request
  endtask : axw
  task automatic axr(input logic [7:0] a);
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    rsp = rr;
    rry <= 1'b0;
    @(posedge clk);
  endtask : axr
  // place the axis, start one method, wait bounded for completion
  task automatic home_run(input shs_row_s r);
    int k;
    i_mot.pos = r.st;
    repeat (6) @(posedge clk);  // switch levels settle through the synchronisers
    axw(shs_pkg::OFS_CTRL, {24'h0, r.m, 4'h1});
    repeat (5) @(posedge clk);
    if (r.spd !== 16'h0) chk({16'h0, spd}, {16'h0, r.spd});
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, run}, 32'h0);
    chk({16'h0, spd}, 32'h0);
    chk({31'h0, done}, 32'h1);
    chk(32'(i_mot.pos >= r.lo && i_mot.pos <= r.hi), 32'h1);
  endtask : home_run
  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    axr(shs_pkg::OFS_HI_SPEED);
    chk(d, {16'h0, shs_pkg::HI_SPEED_RST});
    axr(shs_pkg::OFS_LO_SPEED);
    chk(d, {16'h0, shs_pkg::LO_SPEED_RST});
    axw(shs_pkg::OFS_HI_SPEED, 32'h0000_0200);
    axw(shs_pkg::OFS_LO_SPEED, 32'h0000_0020);
    axw(shs_pkg::OFS_ABS_MT, 32'h0000_0000);
    axw(shs_pkg::OFS_ABS_ST, 32'h0000_012C);
    foreach (rows[i]) home_run(rows[i]);
    axr(shs_pkg::OFS_STATUS);
    chk({31'h0, d[shs_pkg::STAT_DONE_BIT]}, 32'h1);
    // method field beyond ten is refused
    axw(shs_pkg::OFS_CTRL, 32'h0000_00B0);
    chk({30'h0, rsp}, {30'h0, shs_pkg::RESP_SLVERR});
    axr(8'h20);
    chk({30'h0, rsp}, {30'h0, shs_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    // interrupt a long forward run part way
    i_mot.pos = 32'h0C8;
    repeat (6) @(posedge clk);
    axw(shs_pkg::OFS_CTRL, 32'h0000_0041);
    repeat (20) @(posedge clk);
    chk({29'h0, run, dir, done}, 32'h4);
    axw(shs_pkg::OFS_CTRL, 32'h0000_0002);
    repeat (5) @(posedge clk);
    chk({30'h0, run, done}, 32'h0);
    axr(shs_pkg::OFS_STATUS);
    chk({31'h0, d[shs_pkg::STAT_FAIL_BIT]}, 32'h1);
    end_sim;
  end
endmodule : servo_homing_sequencer_test
